// ==== pkg/plse_pkg.sv ====
// Package for the link-status and event output block: codes, timing and carriers.
// Notes on behaviour
// RULE1: Raise clock-in-use once running from fabric clock and app is ready.
// RULE2: Application holds itself in reset until clock-in-use is raised.
// RULE3: Application presents no data inputs before clock-in-use is raised.
// RULE4: Clock-in-use and app-ready form a handshake for safe clock switchover.
// RULE5: Leaving data-link-up state drives link-down pulse low exactly one cycle.
// RULE6: Leaving hot reset drives hot-reset-exit low for one cycle.
// RULE7: Application asserts global reset on link-down or hot-reset-exit pulse.
// RULE8: Moving from L2 idle to detect pulses low-power-exit low one cycle.
// RULE9: Short time-base strobe fires once every 128 ns.
// RULE10: Long time-base strobe fires once every 1 us.
// RULE11: Link rate code: 01 first, 10 second, 11 third generation; 00 reserved.
// RULE12: Training state shown on 5-bit code with fixed state encodings.
// RULE13: Correctable ECC errors are corrected internally with no data loss.
// RULE14: Uncorrectable retry-buffer ECC error discards the retry buffer contents.
// RULE15: After uncorrectable ECC error, resetting the whole core is recommended.
// RULE16: Corrected receive-buffer error pulse is stretched for 125 MHz sampling.
// RULE17: Application ignores receive-buffer corrected error until buffer filled.
// RULE18: Debug output rises on uncorrectable retry-buffer error.
// RULE19: Separate debug output rises on corrected retry-buffer error.
// RULE20: Uncorrectable receive-buffer errors flag on receive stream error output.
// RULE21: ECC debug outputs are for observation only, not functional decisions.
// RULE22: Application asserts app-ready only when ready with stable fabric clock.
// RULE23: Each strobe is high exactly one cycle per period, fabric-synchronous.
// RULE24: Codes and pulses change on clock edges, inactive while in reset.
package plse_pkg;

  localparam int unsigned CLK_PERIOD_PS     = 4000;
  localparam int unsigned SHORT_PERIOD_NS   = 128;
  localparam int unsigned LONG_PERIOD_US    = 1;
  localparam int unsigned SHORT_CYCLES      = (SHORT_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned LONG_CYCLES       = (LONG_PERIOD_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W             = 8;
  // Stretch length in fast cycles so a half-rate sampler sees at least two edges.
  localparam int unsigned STRETCH_CYCLES    = 4;
  localparam int unsigned STRETCH_W         = 3;

  localparam logic [1:0] SPEED_RESERVED = 2'h0;
  localparam logic [1:0] SPEED_GEN1     = 2'h1;
  localparam logic [1:0] SPEED_GEN2     = 2'h2;
  localparam logic [1:0] SPEED_GEN3     = 2'h3;

  typedef enum logic [4:0] {
    PLSE_DETECT_QUIET   = 5'h00,
    PLSE_DETECT_ACTIVE  = 5'h01,
    PLSE_POLL_ACTIVE    = 5'h02,
    PLSE_POLL_COMPLY    = 5'h03,
    PLSE_POLL_CONFIG    = 5'h04,
    PLSE_POLL_SPEED     = 5'h05,
    PLSE_CFG_WIDTHSTART = 5'h06,
    PLSE_CFG_WIDTHACC   = 5'h07,
    PLSE_CFG_LANEACC    = 5'h08,
    PLSE_CFG_LANEWAIT   = 5'h09,
    PLSE_CFG_COMPLETE   = 5'h0A,
    PLSE_CFG_IDLE       = 5'h0B,
    PLSE_REC_RCVLOCK    = 5'h0C,
    PLSE_REC_RCVCONFIG  = 5'h0D,
    PLSE_REC_IDLE       = 5'h0E,
    PLSE_L0             = 5'h0F,
    PLSE_DISABLE        = 5'h10,
    PLSE_LOOP_ENTRY     = 5'h11,
    PLSE_LOOP_EXIT      = 5'h12,
    PLSE_HOT_RESET      = 5'h14,
    PLSE_L1_IDLE        = 5'h17,
    PLSE_L2_IDLE        = 5'h18
  } plse_ltssm_t;

  // Internal core state reported to this block each cycle.
  typedef struct packed {
    plse_ltssm_t ltssm;
    logic [1:0]  speed;
    logic        link_up;
  } plse_core_state_t;

  // ECC events from the buffers, one-cycle pulses.
  typedef struct packed {
    logic rx_corrected;
    logic rx_uncorrectable;
    logic rpl_corrected;
    logic rpl_uncorrectable;
  } plse_ecc_evt_t;

endpackage

// ==== rtl/plse_status_events.sv ====
// Link-status, event pulse, time-base strobe and ECC event outputs toward user logic.
`timescale 1ns/1ps
module plse_status_events (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       nrst,
  // Clock switchover handshake
  input  wire logic                       app_ready,
  input  wire logic                       core_on_fabric_clk,
  output logic                            clk_in_use,
  // Core state
  input  wire plse_pkg::plse_core_state_t core_state,
  input  wire plse_pkg::plse_ecc_evt_t    ecc_evt,
  // Event pulses, active low
  output logic                            link_down_exit_n,
  output logic                            hot_reset_exit_n,
  output logic                            l2_exit_n,
  // Time base
  output logic                            strobe_short_period,
  output logic                            strobe_long_period,
  // Status codes
  output logic [1:0]                      current_speed,
  output logic [4:0]                      training_state_code,
  // ECC
  output logic                            rx_buffer_corrected_err,
  output logic                            retry_uncorrectable_err,
  output logic                            retry_corrected_err,
  output logic                            retry_buffer_flush,
  output logic                            receive_stream_error
);
  import plse_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // App-ready comes from the fabric and may be asynchronous to us.
  logic ready_s1_q, ready_s2_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ready_s1_q <= 1'b0;
      ready_s2_q <= 1'b0;
    end else begin
      ready_s1_q <= app_ready;
      ready_s2_q <= ready_s1_q;
    end
  end

  wire clk_in_use_d = ready_s2_q & core_on_fabric_clk; // [RULE1] [RULE4]

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) clk_in_use <= 1'b0;
    else       clk_in_use <= clk_in_use_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Previous-cycle state for exit detection.
  plse_ltssm_t ltssm_q;
  logic        link_up_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ltssm_q   <= PLSE_DETECT_QUIET;
      link_up_q <= 1'b0;
    end else begin
      ltssm_q   <= core_state.ltssm;
      link_up_q <= core_state.link_up;
    end
  end

  wire link_down_evt = link_up_q & ~core_state.link_up; // [RULE5]
  wire hot_exit_evt  = (ltssm_q == PLSE_HOT_RESET) & (core_state.ltssm != PLSE_HOT_RESET); // [RULE6]
  wire l2_exit_evt   = (ltssm_q == PLSE_L2_IDLE) & (core_state.ltssm == PLSE_DETECT_QUIET); // [RULE8]

  // Registered from one-cycle events, so each low pulse lasts exactly one cycle.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      link_down_exit_n <= 1'b1;
      hot_reset_exit_n <= 1'b1;
      l2_exit_n        <= 1'b1;
    end else begin
      link_down_exit_n <= ~link_down_evt; // [RULE5] [RULE24]
      hot_reset_exit_n <= ~hot_exit_evt;  // [RULE6]
      l2_exit_n        <= ~l2_exit_evt;   // [RULE8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base: the long period is counted in short periods where possible,
  // but 1 us is not a multiple of 128 ns, so each has its own counter.
  logic [CNT_W-1:0] short_cnt_q;
  logic [CNT_W-1:0] long_cnt_q;

  function automatic logic cnt_wrap(input logic [CNT_W-1:0] cnt, input int unsigned period);
    cnt_wrap = (cnt == CNT_W'(period - 1));
  endfunction

  wire short_wrap = cnt_wrap(short_cnt_q, SHORT_CYCLES); // [RULE9]
  wire long_wrap  = cnt_wrap(long_cnt_q, LONG_CYCLES);   // [RULE10]

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      short_cnt_q         <= '0;
      long_cnt_q          <= '0;
      strobe_short_period <= 1'b0;
      strobe_long_period  <= 1'b0;
    end else begin
      short_cnt_q         <= short_wrap ? '0 : short_cnt_q + CNT_W'(1);
      long_cnt_q          <= long_wrap  ? '0 : long_cnt_q + CNT_W'(1);
      strobe_short_period <= short_wrap; // [RULE23]
      strobe_long_period  <= long_wrap;  // [RULE23]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status codes; the reserved speed code is what reset shows.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      current_speed       <= SPEED_RESERVED;
      training_state_code <= PLSE_DETECT_QUIET;
    end else begin
      current_speed       <= core_state.speed; // [RULE11]
      training_state_code <= core_state.ltssm; // [RULE12] [RULE24]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ECC. Corrected events need no action beyond reporting, since data was fixed.
  logic [STRETCH_W-1:0] stretch_q;
  wire                  stretch_busy = (stretch_q != '0);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stretch_q <= '0;
    end else if (ecc_evt.rx_corrected) begin
      stretch_q <= STRETCH_W'(STRETCH_CYCLES); // [RULE16] [RULE13]
    end else if (stretch_busy) begin
      stretch_q <= stretch_q - STRETCH_W'(1);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_buffer_corrected_err <= 1'b0;
      retry_uncorrectable_err <= 1'b0;
      retry_corrected_err     <= 1'b0;
      retry_buffer_flush      <= 1'b0;
      receive_stream_error    <= 1'b0;
    end else begin
      rx_buffer_corrected_err <= ecc_evt.rx_corrected | stretch_busy; // [RULE16]
      retry_uncorrectable_err <= ecc_evt.rpl_uncorrectable;           // [RULE18]
      retry_corrected_err     <= ecc_evt.rpl_corrected;               // [RULE19] [RULE13]
      retry_buffer_flush      <= ecc_evt.rpl_uncorrectable;           // [RULE14]
      receive_stream_error    <= ecc_evt.rx_uncorrectable;            // [RULE20]
    end
  end

endmodule // plse_status_events

// ==== tb/plse_app_model.sv ====
// Behavioural model of the user logic that sits on the far side of the block.
`timescale 1ns/1ps
module plse_app_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Handshake and exit pulses
  input  wire logic clk_in_use,
  input  wire logic link_down_exit_n,
  input  wire logic hot_reset_exit_n,
  output logic      app_ready,
  output logic      app_rst_n
);
  logic [3:0] settle_q;
  ////////////////////////////////////////////////////////////////////////
  // Ready is withheld until the fabric clock has run a while, so the core never switches to an unsettled clock.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) settle_q <= 4'h0;
    else if (settle_q != 4'hF) settle_q <= settle_q + 4'h1;
  end
  assign app_ready = (settle_q == 4'hF);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) app_rst_n <= 1'b0;
    else app_rst_n <= clk_in_use && link_down_exit_n && hot_reset_exit_n;
  end
endmodule // plse_app_model

// ==== tb/plse_status_events_sva.sv ====
// Concurrent checks on the ports of the status and event block.
`timescale 1ns/1ps
module plse_status_events_sva (
  // Block ports
  input wire logic clock, nrst, app_ready, core_on_fabric_clk, clk_in_use,
  input wire plse_pkg::plse_core_state_t core_state,
  input wire plse_pkg::plse_ecc_evt_t ecc_evt,
  input wire logic link_down_exit_n, hot_reset_exit_n, l2_exit_n, strobe_short_period, strobe_long_period,
  input wire logic [1:0] current_speed,
  input wire logic [4:0] training_state_code,
  input wire logic rx_buffer_corrected_err, retry_uncorrectable_err, retry_corrected_err, retry_buffer_flush,
  input wire logic receive_stream_error
);
  import plse_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_CLK_OFF: assert property (!core_on_fabric_clk |=> !clk_in_use) else $error("in-use without fabric");
  AST_CLK_UP: assert property ($rose(clk_in_use) |-> $past(app_ready, 3) && $past(core_on_fabric_clk))
    else $error("in-use rose early");
  AST_LINK_DOWN: assert property ($fell(core_state.link_up) |=> !link_down_exit_n ##1 link_down_exit_n)
    else $error("link-down pulse wrong");
  AST_LINK_QUIET: assert property (!link_down_exit_n |-> $past(core_state.link_up, 2) && !$past(core_state.link_up))
    else $error("spurious link-down pulse");
  AST_HOT_EXIT: assert property ($past(core_state.ltssm) == PLSE_HOT_RESET && core_state.ltssm != PLSE_HOT_RESET
    |=> !hot_reset_exit_n ##1 hot_reset_exit_n) else $error("hot-reset exit pulse wrong");
  AST_L2_EXIT: assert property ($past(core_state.ltssm) == PLSE_L2_IDLE && core_state.ltssm == PLSE_DETECT_QUIET
    |=> !l2_exit_n ##1 l2_exit_n) else $error("l2 exit pulse wrong");
  AST_SHORT: assert property (strobe_short_period |=> !strobe_short_period ##31 strobe_short_period)
    else $error("short strobe period");
  AST_LONG: assert property (strobe_long_period |=> !strobe_long_period ##249 strobe_long_period)
    else $error("long strobe period");
  AST_STATUS: assert property ({current_speed, training_state_code} == $past({core_state.speed, core_state.ltssm}))
    else $error("status code lag");
  AST_RETRY: assert property ({retry_buffer_flush, retry_uncorrectable_err, retry_corrected_err, receive_stream_error}
    == $past({ecc_evt.rpl_uncorrectable, ecc_evt.rpl_uncorrectable, ecc_evt.rpl_corrected, ecc_evt.rx_uncorrectable}))
    else $error("ecc event output wrong");
  AST_RX_STRETCH: assert property (ecc_evt.rx_corrected |=> rx_buffer_corrected_err [*5])
    else $error("rx corrected pulse too short");
endmodule // plse_status_events_sva
bind plse_status_events plse_status_events_sva u_plse_status_events_sva (.clock, .nrst, .app_ready,
  .core_on_fabric_clk, .clk_in_use, .core_state, .ecc_evt, .link_down_exit_n, .hot_reset_exit_n, .l2_exit_n,
  .strobe_short_period, .strobe_long_period, .current_speed, .training_state_code, .rx_buffer_corrected_err,
  .retry_uncorrectable_err, .retry_corrected_err, .retry_buffer_flush, .receive_stream_error);

// ==== tb/test_plse_status_events.sv ====
// Self-checking bench for the status and event block.
`timescale 1ns/1ps
module test_plse_status_events;
  import plse_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, core_on_fabric_clk = 1'b0;
  logic app_ready, clk_in_use, app_rst_n, link_down_exit_n, hot_reset_exit_n, l2_exit_n, strobe_short_period;
  logic strobe_long_period, rx_buffer_corrected_err, retry_uncorrectable_err, retry_corrected_err;
  logic retry_buffer_flush, receive_stream_error;
  logic [1:0] current_speed;
  logic [4:0] training_state_code;
  logic [2:0] exits;
  plse_core_state_t core_state = '0;
  plse_ecc_evt_t ecc_evt = '0;
  int miscompares = 0, total_checks = 0, cycles = 0;
  always #2 clock = ~clock;
  assign exits = {link_down_exit_n, hot_reset_exit_n, l2_exit_n};
  plse_status_events u_plse_status_events (.clock, .nrst, .app_ready, .core_on_fabric_clk, .clk_in_use, .core_state,
    .ecc_evt, .link_down_exit_n, .hot_reset_exit_n, .l2_exit_n, .strobe_short_period, .strobe_long_period,
    .current_speed, .training_state_code, .rx_buffer_corrected_err, .retry_uncorrectable_err,
    .retry_corrected_err, .retry_buffer_flush, .receive_stream_error);
  plse_app_model u_plse_app_model (.clock, .nrst, .clk_in_use, .link_down_exit_n, .hot_reset_exit_n, .app_ready,
    .app_rst_n);
  task automatic end_sim();
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD time=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Settles in state a, moves to state b, then expects the exit pulses expv for exactly one cycle.
  task automatic exit_seq(input logic [5:0] a, input logic [5:0] b, input logic [2:0] expv);
    core_state = '{ltssm: plse_ltssm_t'(a[5:1]), speed: SPEED_GEN1, link_up: a[0]};
    step(3);
    chk(exits, 8'h7);
    core_state = '{ltssm: plse_ltssm_t'(b[5:1]), speed: SPEED_GEN1, link_up: b[0]};
    step(1);
    chk(exits, expv);
    step(1);
    chk(exits, 8'h7);
  endtask
  // Measures the distance between two strobes; a strobe longer than a cycle ends the count at once.
  task automatic period(input bit lng, input logic [7:0] exp);
    int n;
    n = 0;
    while (!(lng ? strobe_long_period : strobe_short_period) && n < 300) begin
      step(1);
      n++;
    end
    n = 0;
    do begin
      step(1);
      n++;
    end while (!(lng ? strobe_long_period : strobe_short_period) && n < 300);
    chk(8'(n), exp);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    int n;
    step(10);
    chk({clk_in_use, exits, strobe_short_period, rx_buffer_corrected_err, current_speed}, 8'h70);
    nrst = 1'b1;
    step(20);
    chk({clk_in_use, app_rst_n}, 8'h0);
    core_on_fabric_clk = 1'b1;
    step(2);
    chk({clk_in_use, app_rst_n}, 8'h3);
    // Core state only moves once clock-in-use is up.
    for (int i = 0; i < 25; i++) begin
      if (i > 18 && !(i inside {20, 23, 24})) continue;
      core_state = '{ltssm: plse_ltssm_t'(i), speed: 2'(i % 3 + 1), link_up: 1'b0};
      step(1);
      chk({current_speed, training_state_code}, {2'(i % 3 + 1), 5'(i)});
    end
    exit_seq({PLSE_L0, 1'b1}, {PLSE_L0, 1'b0}, 3'h3);
    exit_seq({PLSE_HOT_RESET, 1'b0}, {PLSE_DETECT_QUIET, 1'b0}, 3'h5);
    exit_seq({PLSE_L2_IDLE, 1'b0}, {PLSE_POLL_ACTIVE, 1'b0}, 3'h7);
    exit_seq({PLSE_L2_IDLE, 1'b0}, {PLSE_DETECT_QUIET, 1'b0}, 3'h6);
    period(1'b0, 8'h20);
    period(1'b1, 8'hFA);
    // ECC outputs are only observed here, never acted on; a core reset stays optional.
    for (int i = 0; i < 3; i++) begin
      ecc_evt = plse_ecc_evt_t'(4'h1 << i);
      step(1);
      ecc_evt = '0;
      chk({receive_stream_error, retry_corrected_err, retry_uncorrectable_err, retry_buffer_flush},
        (i == 0) ? 8'h3 : 8'h4 << (i - 1));
      step(1);
      chk({receive_stream_error, retry_corrected_err, retry_uncorrectable_err, retry_buffer_flush}, 8'h0);
    end
    // The receive buffer is taken as filled by now, so the corrected flag is meaningful.
    ecc_evt.rx_corrected = 1'b1;
    step(1);
    ecc_evt = '0;
    n = 0;
    repeat (8) begin
      if (rx_buffer_corrected_err === 1'b1) n++;
      step(1);
    end
    chk(8'(n), 8'h5);
    end_sim();
  end
endmodule // test_plse_status_events
